/* File: hdl/dbaod_consts.svh */
// How it works
// - ODT pin switches termination on data pins
// - Self refresh forces termination off
// - Bits A6,A2 select 75, 150, 50 ohms
// - Activate: CS#, RAS# low, CAS#, WE# high
// - Activate takes bank BA0-BA2, row A0-A12
// - Column command accepted cycle after activate
// - Column: RAS# high, CS#, CAS# low; WE# picks
// - One command yields a whole serial burst
// - Burst column wraps inside its segment
// - Posted command delayed by additive latency
// - Read latency is additive plus CAS latency
// - Write latency is read latency minus one
// - Back-to-back bursts run without gap
// - AL from extended register, CL from main
`ifndef DBAOD_CONSTS_SVH
`define DBAOD_CONSTS_SVH

`define DBAOD_BANKS      8
`define DBAOD_ROW_W      13
`define DBAOD_COL_W      10
`define DBAOD_CNT_W      16
`define DBAOD_AL_MAX     3'h4
`define DBAOD_FIFO_DEPTH 4
`define DBAOD_PIPE_N     8
`define DBAOD_AP_BIT     10
`define DBAOD_RTT_OFF    2'h0
`define DBAOD_RTT_75     2'h1
`define DBAOD_RTT_150    2'h2
`define DBAOD_RTT_50     2'h3
`define DBAOD_TCK_NS     64
`define DBAOD_TFAW_NS    450
`define DBAOD_TRP_NS     150

`endif

/* File: hdl/dbaod_pkg.sv */
`default_nettype none
package dbaod_pkg;

    // Pins of the command link, synchronised as one group
    typedef struct packed {
        logic        ck;
        logic        cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [2:0]  ba;
        logic [12:0] addr;
        logic        odt;
    } dbaod_pins_t;

    // Posted column command with its arrival stamp
    typedef struct packed {
        logic        wr;
        logic        ap;
        logic [2:0]  bank;
        logic [9:0]  col;
        logic [15:0] stamp;
    } dbaod_col_t;

    // Entry of the latency pipeline
    typedef struct packed {
        logic       vld;
        logic       wr;
        logic [2:0] bank;
        logic [9:0] col;
    } dbaod_beat_t;

    typedef enum logic [1:0] {
        BURST_IDLE  = 2'b00,
        BURST_READ  = 2'b01,
        BURST_WRITE = 2'b10
    } dbaod_burst_t;

endpackage
`default_nettype wire

/* File: hdl/dbaod_fifo.sv */
`default_nettype none
module dbaod_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    // Fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // Drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [AW:0]   cnt_q;
    wire           push_w = in_valid_i && in_ready_o;
    wire           pop_w  = out_valid_o && out_ready_i;
    wire [AW-1:0]  wnext_w = (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
    wire [AW-1:0]  rnext_w = (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;

    assign in_ready_o  = (cnt_q != (AW + 1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rptr_q];

    always_ff @(posedge sys_clk_i)
    begin
        if (push_w)
        begin
            mem_q[wptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q  <= '0;
        end
        else
        begin
            wptr_q <= push_w ? wnext_w : wptr_q;
            rptr_q <= pop_w ? rnext_w : rptr_q;
            cnt_q  <= cnt_q + (AW + 1)'(push_w) - (AW + 1)'(pop_w);
        end
    end
endmodule
`default_nettype wire

/* File: hdl/dbaod_top.sv */
`include "dbaod_consts.svh"
`default_nettype none
module dbaod_top #(
    parameter int TCK_NS  = `DBAOD_TCK_NS,
    parameter int TFAW_NS = `DBAOD_TFAW_NS,
    parameter int TRP_NS  = `DBAOD_TRP_NS
) (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    // Command link pins
    input  wire logic        ck_i,
    input  wire logic        cs_n_i,
    input  wire logic        ras_n_i,
    input  wire logic        cas_n_i,
    input  wire logic        we_n_i,
    input  wire logic [2:0]  ba_i,
    input  wire logic [12:0] addr_i,
    input  wire logic        odt_i,
    // Mode register fields and power state
    input  wire logic [2:0]  al_i,
    input  wire logic [2:0]  cl_i,
    input  wire logic        rtt_a6_i,
    input  wire logic        rtt_a2_i,
    input  wire logic        bl8_i,
    input  wire logic        self_refresh_i,
    // Termination
    output logic             odt_en_o,
    output logic [1:0]       rtt_sel_o,
    // Bank state and checks
    output logic [7:0]       bank_open_o,
    output logic             act_pulse_o,
    output logic [2:0]       act_bank_o,
    output logic [12:0]      act_row_o,
    output logic             illegal_o,
    output logic             faw_err_o,
    output logic             pall_err_o,
    // Posted command queue
    output logic             cmd_ready_o,
    output logic             overflow_o,
    output logic             exec_pulse_o,
    output logic             exec_wr_o,
    output logic [2:0]       exec_bank_o,
    // Data burst
    output logic             rd_act_o,
    output logic             wr_act_o,
    output logic [2:0]       burst_bank_o,
    output logic [9:0]       burst_col_o
);
    localparam int FAW_CK = (TFAW_NS + TCK_NS - 1) / TCK_NS;
    localparam int TRP_CK = (TRP_NS + TCK_NS - 1) / TCK_NS;
    localparam int CW     = `DBAOD_CNT_W;
    localparam int PN     = `DBAOD_PIPE_N;
    localparam logic [CW-1:0] FAW_W  = CW'(FAW_CK);
    localparam logic [CW-1:0] PALL_W = CW'(TRP_CK + 1);
    localparam int QW = $bits(dbaod_pkg::dbaod_col_t);

    // Two flops on every pin; s1 feeds only s2
    dbaod_pkg::dbaod_pins_t pin_w;
    dbaod_pkg::dbaod_pins_t s1_q;
    dbaod_pkg::dbaod_pins_t s2_q;
    logic                   ck_d1_q;
    assign pin_w = '{ck_i, cs_n_i, ras_n_i, cas_n_i, we_n_i,
                     ba_i, addr_i, odt_i};

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            s1_q    <= '{default: '0, cs_n: 1'b1};
            s2_q    <= '{default: '0, cs_n: 1'b1};
            ck_d1_q <= 1'b0;
        end
        else
        begin
            s1_q    <= pin_w;
            s2_q    <= s1_q;
            ck_d1_q <= s2_q.ck;
        end
    end

    // Command decode on each link clock rising edge
    wire tick_w = s2_q.ck && !ck_d1_q;
    wire act_w  = tick_w && !s2_q.cs_n && !s2_q.ras_n
                  && s2_q.cas_n && s2_q.we_n;
    wire col_w  = tick_w && !s2_q.cs_n && s2_q.ras_n
                  && !s2_q.cas_n;
    wire pre_w  = tick_w && !s2_q.cs_n && !s2_q.ras_n
                  && s2_q.cas_n && !s2_q.we_n;
    wire pall_w = pre_w && s2_q.addr[`DBAOD_AP_BIT];

    // Termination gating
    wire [1:0] rtt_w = {rtt_a6_i, rtt_a2_i};
    wire odt_on_w = s2_q.odt && !self_refresh_i
                    && (rtt_w != `DBAOD_RTT_OFF);

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            odt_en_o  <= 1'b0;
            rtt_sel_o <= `DBAOD_RTT_OFF;
        end
        else
        begin
            odt_en_o  <= odt_on_w;
            rtt_sel_o <= rtt_w;
        end
    end

    // Link clock counter stamps commands
    logic [CW-1:0] cnt_q;
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            cnt_q <= '0;
        else if (tick_w)
            cnt_q <= cnt_q + 1'b1;
    end

    // Activate window history, oldest entry at the ring pointer
    logic [CW-1:0] hist_q [4];
    logic [3:0]    hist_vld_q;
    logic [1:0]    hist_ptr_q;
    logic [CW-1:0] pall_stamp_q;
    logic          pall_seen_q;
    wire faw_hit_w  = hist_vld_q[hist_ptr_q]
                      && ((cnt_q - hist_q[hist_ptr_q]) < FAW_W);
    wire pall_hit_w = pall_seen_q
                      && ((cnt_q - pall_stamp_q) < PALL_W);

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            hist_q       <= '{default: '0};
            hist_vld_q   <= '0;
            hist_ptr_q   <= '0;
            pall_stamp_q <= '0;
            pall_seen_q  <= 1'b0;
        end
        else
        begin
            if (act_w)
            begin
                hist_q[hist_ptr_q]     <= cnt_q;
                hist_vld_q[hist_ptr_q] <= 1'b1;
                hist_ptr_q             <= hist_ptr_q + 1'b1;
            end
            if (pall_w)
            begin
                pall_stamp_q <= cnt_q;
                pall_seen_q  <= 1'b1;
            end
        end
    end

    // Posted command queue and its execution point
    logic                   q_ready_w;
    logic                   q_valid_w;
    dbaod_pkg::dbaod_col_t  q_in_w;
    dbaod_pkg::dbaod_col_t  q_head_w;
    wire [2:0] al_w = (al_i > `DBAOD_AL_MAX) ? `DBAOD_AL_MAX : al_i;
    wire col_ok_w  = col_w && bank_open_o[s2_q.ba];
    wire due_w     = (cnt_q - q_head_w.stamp) >= CW'(al_w);
    // Execute between edges so the pipeline never sees both at once
    wire issue_w   = q_valid_w && due_w && !tick_w;
    assign q_in_w  = '{!s2_q.we_n, s2_q.addr[`DBAOD_AP_BIT], s2_q.ba,
                       s2_q.addr[9:0], cnt_q + 1'b1};

    dbaod_fifo #(
        .W     (QW),
        .DEPTH (`DBAOD_FIFO_DEPTH)
    ) u_queue (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (col_ok_w),
        .in_ready_o  (q_ready_w),
        .in_data_i   (q_in_w),
        .out_valid_o (q_valid_w),
        .out_ready_i (issue_w),
        .out_data_o  (q_head_w)
    );

    // Bank state, one flop per bank
    genvar gb;
    generate
        for (gb = 0; gb < `DBAOD_BANKS; gb++)
        begin : g_bank
            wire open_w  = act_w && (s2_q.ba == 3'(gb));
            wire close_w = (pre_w && (pall_w || s2_q.ba == 3'(gb)))
                           || (issue_w && q_head_w.ap
                               && q_head_w.bank == 3'(gb));
            always_ff @(posedge sys_clk_i)
            begin
                if (!rst_n_i)
                    bank_open_o[gb] <= 1'b0;
                else if (open_w)
                    bank_open_o[gb] <= 1'b1;
                else if (close_w)
                    bank_open_o[gb] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            act_pulse_o  <= 1'b0;
            act_bank_o   <= '0;
            act_row_o    <= '0;
            illegal_o    <= 1'b0;
            faw_err_o    <= 1'b0;
            pall_err_o   <= 1'b0;
            cmd_ready_o  <= 1'b1;
            overflow_o   <= 1'b0;
            exec_pulse_o <= 1'b0;
            exec_wr_o    <= 1'b0;
            exec_bank_o  <= '0;
        end
        else
        begin
            act_pulse_o  <= act_w;
            act_bank_o   <= act_w ? s2_q.ba : act_bank_o;
            act_row_o    <= act_w ? s2_q.addr : act_row_o;
            // Undefined results are flagged; a column to a closed bank is dropped, an activate to an open bank still executes
            illegal_o    <= (col_w && !bank_open_o[s2_q.ba])
                            || (act_w && bank_open_o[s2_q.ba]);
            faw_err_o    <= act_w && faw_hit_w;
            pall_err_o   <= act_w && pall_hit_w;
            cmd_ready_o  <= q_ready_w;
            overflow_o   <= col_ok_w && !q_ready_w;
            exec_pulse_o <= issue_w;
            exec_wr_o    <= issue_w ? q_head_w.wr : exec_wr_o;
            exec_bank_o  <= issue_w ? q_head_w.bank : exec_bank_o;
        end
    end

    // Latency pipeline: read waits CL edges, write one fewer
    wire [2:0] lat_raw_w = q_head_w.wr ? cl_i - 1'b1 : cl_i;
    wire [2:0] lat_w     = (lat_raw_w == 3'h0) ? 3'h1 : lat_raw_w;
    dbaod_pkg::dbaod_beat_t pipe_q [PN];
    dbaod_pkg::dbaod_beat_t ins_w;
    assign ins_w = '{1'b1, q_head_w.wr, q_head_w.bank, q_head_w.col};

    genvar gp;
    generate
        for (gp = 0; gp < PN; gp++)
        begin : g_pipe
            wire load_w = issue_w && (lat_w - 1'b1 == 3'(gp));
            dbaod_pkg::dbaod_beat_t up_w;
            if (gp == PN - 1)
            begin : g_top
                assign up_w = '0;
            end
            else
            begin : g_mid
                assign up_w = pipe_q[gp + 1];
            end
            always_ff @(posedge sys_clk_i)
            begin
                if (!rst_n_i)
                    pipe_q[gp] <= '0;
                else if (tick_w)
                    pipe_q[gp] <= up_w;
                else if (load_w)
                    pipe_q[gp] <= ins_w;
            end
        end
    endgenerate

    // Burst engine: BL/2 link clocks per command
    dbaod_pkg::dbaod_burst_t bst_q;
    dbaod_pkg::dbaod_burst_t bst_d;
    logic [1:0] beat_q;
    logic [9:0] start_q;
    wire  [1:0] last_w  = bl8_i ? 2'h3 : 2'h1;
    wire        start_w = tick_w && pipe_q[0].vld;
    wire        busy_w  = (bst_q != dbaod_pkg::BURST_IDLE);
    wire  [1:0] beat_d  = start_w ? 2'h0 : beat_q + 1'b1;
    wire  [9:0] base_w  = start_w ? pipe_q[0].col : start_q;
    wire  [2:0] off_w   = base_w[2:0] + {beat_d, 1'b0};
    // Only the low bits move, so the segment boundary is never crossed
    wire  [9:0] col_d   = bl8_i ? {base_w[9:3], off_w}
                                : {base_w[9:2], off_w[1:0]};

    always_comb
    begin
        bst_d = bst_q;
        if (start_w)
            bst_d = pipe_q[0].wr ? dbaod_pkg::BURST_WRITE
                                 : dbaod_pkg::BURST_READ;
        else if (tick_w && busy_w && beat_q == last_w)
            bst_d = dbaod_pkg::BURST_IDLE;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            bst_q        <= dbaod_pkg::BURST_IDLE;
            beat_q       <= '0;
            start_q      <= '0;
            rd_act_o     <= 1'b0;
            wr_act_o     <= 1'b0;
            burst_bank_o <= '0;
            burst_col_o  <= '0;
        end
        else
        begin
            bst_q    <= bst_d;
            rd_act_o <= (bst_d == dbaod_pkg::BURST_READ);
            wr_act_o <= (bst_d == dbaod_pkg::BURST_WRITE);
            if (start_w || (tick_w && busy_w))
            begin
                beat_q      <= beat_d;
                start_q     <= base_w;
                burst_col_o <= col_d;
            end
            if (start_w)
                burst_bank_o <= pipe_q[0].bank;
        end
    end

    // Checks
    sequence s_act;
        act_w;
    endsequence

    sequence s_faw_act;
        act_w && faw_hit_w;
    endsequence

    property p_odt_sr;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        self_refresh_i |=> !odt_en_o;
    endproperty
    a_odt_sr: assert property (p_odt_sr)
        else $error("termination on in self refresh");

    property p_odt_rtt0;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (rtt_w == `DBAOD_RTT_OFF) |=> !odt_en_o;
    endproperty
    a_odt_rtt0: assert property (p_odt_rtt0)
        else $error("termination on with zero rtt");

    property p_odt_follow;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (odt_i && !self_refresh_i && rtt_w != 2'h0) [*3]
        |=> odt_en_o;
    endproperty
    a_odt_follow: assert property (p_odt_follow)
        else $error("odt pin not followed");

    property p_act_open;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        s_act |=> act_pulse_o && bank_open_o[act_bank_o];
    endproperty
    a_act_open: assert property (p_act_open)
        else $error("activate did not open bank");

    property p_illegal;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        col_w && !bank_open_o[s2_q.ba] |=> illegal_o && !exec_pulse_o[*1];
    endproperty
    a_illegal: assert property (p_illegal)
        else $error("closed bank column not flagged");

    property p_faw;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        s_faw_act |=> faw_err_o;
    endproperty
    a_faw: assert property (p_faw)
        else $error("four activate window not flagged");

    property p_issue_age;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        issue_w |-> (cnt_q - q_head_w.stamp) >= CW'(al_w)
                    ##1 exec_pulse_o;
    endproperty
    a_issue_age: assert property (p_issue_age)
        else $error("posted command issued early");

    property p_burst_start;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        start_w |=> (rd_act_o != wr_act_o)
                    && burst_bank_o == $past(pipe_q[0].bank);
    endproperty
    a_burst_start: assert property (p_burst_start)
        else $error("burst did not start");

    property p_wrap;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (rd_act_o || wr_act_o) && bl8_i |-> burst_col_o[9:3] == start_q[9:3];
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("burst crossed segment");
endmodule
`default_nettype wire

/* File: verification/dbaod_ctl_model.sv */
`default_nettype none
module dbaod_ctl_model (
    // Link clock and command pins
    output logic        ck_o,
    output logic        cs_n_o,
    output logic        ras_n_o,
    output logic        cas_n_o,
    output logic        we_n_o,
    output logic [2:0]  ba_o,
    output logic [12:0] addr_o,
    // Termination request
    output logic        odt_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Free-running link clock, offset from the system clock edges
    initial
    begin
        ck_o = 1'b0;
        cs_n_o = 1'b1;
        ras_n_o = 1'b1;
        cas_n_o = 1'b1;
        we_n_o = 1'b1;
        ba_o = 3'h0;
        addr_o = 13'h0000;
        odt_o = 1'b0;
        #3;
        forever #32 ck_o = ~ck_o;
    end

    // Pins move on ck falling so they straddle the sampled rise
    task automatic cmd(input logic ras_n, cas_n, we_n,
                       input logic [2:0] ba, input logic [12:0] addr);
        cs_n_o = 1'b0;
        ras_n_o = ras_n;
        cas_n_o = cas_n;
        we_n_o = we_n;
        ba_o = ba;
        addr_o = addr;
        @(negedge ck_o);
    endtask

    // Deselected lines flip so stale values never pass for a command
    task automatic idle(input int n);
        cs_n_o = 1'b1;
        ras_n_o = ~ras_n_o;
        cas_n_o = ~cas_n_o;
        we_n_o = ~we_n_o;
        ba_o = ~ba_o;
        addr_o = ~addr_o;
        repeat (n) @(negedge ck_o);
    endtask

    task automatic set_odt(input logic v);
        @(negedge ck_o);
        odt_o = v;
    endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
`include "dbaod_consts.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FAW_W = (`DBAOD_TFAW_NS + `DBAOD_TCK_NS - 1) / `DBAOD_TCK_NS;
    localparam int PALL_W = (`DBAOD_TRP_NS + `DBAOD_TCK_NS - 1)
                            / `DBAOD_TCK_NS + 1;
    logic        sys_clk_i, rst_n_i, ck_i, cs_n_i, ras_n_i, cas_n_i, we_n_i;
    logic [2:0]  ba_i, al_i, cl_i, act_bank_o, exec_bank_o, burst_bank_o;
    logic [12:0] addr_i, act_row_o;
    logic        odt_i, rtt_a6_i, rtt_a2_i, bl8_i, self_refresh_i;
    logic        odt_en_o, act_pulse_o, illegal_o, faw_err_o, pall_err_o;
    logic        cmd_ready_o, overflow_o, exec_pulse_o, exec_wr_o;
    logic        rd_act_o, wr_act_o, prev_act, first_wr;
    logic [1:0]  rtt_sel_o;
    logic [7:0]  bank_open_o;
    logic [9:0]  burst_col_o, first_col, second_col;
    int          fails = 0, total_checks = 0, tick_n = 0, cyc = 0, dur = 0;
    int          acts = 0, ills = 0, faws = 0, palls = 0, execs = 0;
    int          rise_tick = 0, ovfs = 0;

    dbaod_ctl_model ctl (.ck_o(ck_i), .cs_n_o(cs_n_i), .ras_n_o(ras_n_i),
        .cas_n_o(cas_n_i), .we_n_o(we_n_i), .ba_o(ba_i), .addr_o(addr_i),
        .odt_o(odt_i));

    dbaod_top uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ck_i(ck_i),
        .cs_n_i(cs_n_i), .ras_n_i(ras_n_i), .cas_n_i(cas_n_i),
        .we_n_i(we_n_i), .ba_i(ba_i), .addr_i(addr_i), .odt_i(odt_i),
        .al_i(al_i), .cl_i(cl_i), .rtt_a6_i(rtt_a6_i), .rtt_a2_i(rtt_a2_i),
        .bl8_i(bl8_i), .self_refresh_i(self_refresh_i),
        .odt_en_o(odt_en_o), .rtt_sel_o(rtt_sel_o),
        .bank_open_o(bank_open_o), .act_pulse_o(act_pulse_o),
        .act_bank_o(act_bank_o), .act_row_o(act_row_o),
        .illegal_o(illegal_o), .faw_err_o(faw_err_o),
        .pall_err_o(pall_err_o), .cmd_ready_o(cmd_ready_o),
        .overflow_o(overflow_o), .exec_pulse_o(exec_pulse_o),
        .exec_wr_o(exec_wr_o), .exec_bank_o(exec_bank_o),
        .rd_act_o(rd_act_o), .wr_act_o(wr_act_o),
        .burst_bank_o(burst_bank_o), .burst_col_o(burst_col_o));

    always #4 sys_clk_i = ~sys_clk_i;
    always @(posedge ck_i) tick_n <= tick_n + 1;

    // Pulses are tallied so scenarios can compare counts afterwards
    always @(posedge sys_clk_i)
    begin
        cyc <= cyc + 1;
        acts <= acts + int'(act_pulse_o);
        ills <= ills + int'(illegal_o);
        faws <= faws + int'(faw_err_o);
        palls <= palls + int'(pall_err_o);
        execs <= execs + int'(exec_pulse_o);
        ovfs <= ovfs + int'(overflow_o);
        prev_act <= rd_act_o | wr_act_o;
        if ((rd_act_o | wr_act_o) && !prev_act)
        begin
            rise_tick <= tick_n;
            first_col <= burst_col_o;
            first_wr <= wr_act_o;
        end
        if ((rd_act_o | wr_act_o) && dur == 8)
            second_col <= burst_col_o;
        if (rd_act_o | wr_act_o)
            dur <= dur + 1;
        if (cyc == 20000)
        begin
            fails++;
            close_out();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic t_odt();
        for (int k = 0; k < 16; k++)
        begin
            ctl.set_odt(k[3]);
            @(negedge sys_clk_i);
            {self_refresh_i, rtt_a6_i, rtt_a2_i} = k[2:0];
            repeat (6) @(negedge sys_clk_i);
            check("odt enable", odt_en_o, k[3] & ~k[2] & (k[1] | k[0]));
            check("rtt select", rtt_sel_o, k[1:0]);
        end
        self_refresh_i = 1'b0;
        ctl.set_odt(1'b0);
    endtask

    task automatic t_act();
        int a0, i0, e0;
        a0 = acts;
        i0 = ills;
        e0 = execs;
        @(negedge ck_i);
        ctl.cmd(1'b0, 1'b1, 1'b1, 3'h2, 13'h1ABC);
        ctl.cmd(1'b0, 1'b1, 1'b0, 3'h3, 13'h0000);
        ctl.cmd(1'b1, 1'b0, 1'b1, 3'h5, 13'h0010);
        ctl.idle(10);
        check("activates", acts - a0, 1);
        check("act bank", act_bank_o, 3'h2);
        check("act row", act_row_o, 13'h1ABC);
        check("open banks", bank_open_o, 8'h04);
        check("closed column flagged", ills - i0, 1);
        check("closed column dropped", execs - e0, 0);
    endtask

    task automatic col_burst(input logic act, wr, input logic [2:0] al, cl,
                             input logic bl8, input logic [9:0] col,
                             input int n);
        int beats, t0, e0;
        logic [9:0] seg;
        beats = bl8 ? 4 : 2;
        seg = bl8 ? 10'h007 : 10'h003;
        @(negedge sys_clk_i);
        al_i = al;
        cl_i = cl;
        bl8_i = bl8;
        dur = 0;
        e0 = execs;
        t0 = 0;
        @(negedge ck_i);
        if (act)
            ctl.cmd(1'b0, 1'b1, 1'b1, 3'h1, 13'h0042);
        for (int i = 0; i < n; i++)
        begin
            ctl.cmd(1'b1, 1'b0, ~wr, 3'h1, {3'h0, col});
            if (i == 0)
                t0 = tick_n;
            ctl.idle(beats - 1);
        end
        ctl.idle(12);
        check("latency", rise_tick - t0, al + cl - wr);
        check("burst cycles", dur, n * beats * 8);
        check("burst kind", first_wr, wr);
        check("first column", first_col, col);
        check("second column", second_col, (col & ~seg) | ((col + 2) & seg));
        check("executed", execs - e0, n);
        check("exec kind", exec_wr_o, wr);
        check("exec bank", exec_bank_o, 3'h1);
        check("burst bank", burst_bank_o, 3'h1);
    endtask

    task automatic t_limits();
        int i0, f0, p0;
        i0 = ills;
        f0 = faws;
        p0 = palls;
        @(negedge ck_i);
        ctl.cmd(1'b0, 1'b1, 1'b1, 3'h2, 13'h0001);
        ctl.idle(FAW_W);
        for (int b = 3; b < 8; b++)
            ctl.cmd(1'b0, 1'b1, 1'b1, 3'(b), 13'h0002);
        ctl.idle(FAW_W);
        check("reopen flagged", ills - i0, 1);
        check("window flagged", faws - f0, 1);
        ctl.cmd(1'b0, 1'b1, 1'b0, 3'h0, 13'h0400);
        ctl.idle(PALL_W - 3);
        ctl.cmd(1'b0, 1'b1, 1'b1, 3'h6, 13'h0003);
        ctl.cmd(1'b0, 1'b1, 1'b0, 3'h0, 13'h0400);
        ctl.idle(PALL_W - 1);
        ctl.cmd(1'b0, 1'b1, 1'b1, 3'h4, 13'h0004);
        ctl.idle(3);
        check("early activate flagged", palls - p0, 1);
        check("open banks", bank_open_o, 8'h10);
    endtask

    // Four posted reads fill the queue before the first one is due
    task automatic t_full();
        int o0, e0;
        o0 = ovfs;
        e0 = execs;
        @(negedge sys_clk_i);
        al_i = 3'h4;
        @(negedge ck_i);
        for (int i = 0; i < 4; i++)
            ctl.cmd(1'b1, 1'b0, 1'b1, 3'h4, 13'h0000);
        check("queue full", cmd_ready_o, 1'b0);
        ctl.cmd(1'b1, 1'b0, 1'b1, 3'h4, 13'h0000);
        ctl.idle(16);
        check("column dropped", ovfs - o0, 1);
        check("queue executed", execs - e0, 4);
        check("queue drained", cmd_ready_o, 1'b1);
    endtask

    initial
    begin
        sys_clk_i = 1'b0;
        rst_n_i = 1'b0;
        al_i = 3'h0;
        cl_i = 3'h3;
        rtt_a6_i = 1'b0;
        rtt_a2_i = 1'b0;
        bl8_i = 1'b0;
        self_refresh_i = 1'b0;
        repeat (6) @(negedge sys_clk_i);
        check("reset ready", cmd_ready_o, 1'b1);
        check("reset banks", bank_open_o, 8'h00);
        rst_n_i = 1'b1;
        t_odt();
        t_act();
        col_burst(1'b1, 1'b0, 3'h2, 3'h3, 1'b0, 10'h006, 1);
        col_burst(1'b0, 1'b1, 3'h2, 3'h3, 1'b0, 10'h000, 2);
        col_burst(1'b0, 1'b0, 3'h4, 3'h4, 1'b1, 10'h003, 1);
        col_burst(1'b0, 1'b0, 3'h0, 3'h2, 1'b0, 10'h001, 2);
        t_limits();
        t_full();
        close_out();
    end
endmodule
`default_nettype wire
